// ==== src/frame_dma_engine.sv ====
`timescale 1ns/10ps
`include "frame_dma_defs.svh"
module frame_dma_engine import frame_dma_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Channel events from the transfer logic
  input wire logic [`NUM_CH-1:0] frame_event,
  input wire logic [`NUM_CH-1:0] tagged_descriptor_event,
  input wire logic [`NUM_CH-1:0] link_pointer_event,
  input wire logic [`NUM_CH-1:0] fault_event,
  // Descriptor completion, after the completion word is written back
  input wire logic [`NUM_CH-1:0] desc_done,
  input wire logic [`NUM_CH-1:0] desc_done_eof,
  // Descriptor load
  input wire logic desc_load,
  input wire logic [1:0] desc_load_ch,
  input wire logic [31:0] desc_addr,
  input wire logic [31:0] buffer_pointer,
  output logic [31:0] data_start_addr,
  output logic [31:0] status_word_addr,
  output logic [1:0] load_ch,
  // Channel service requests toward the queuing system
  input wire logic [`NUM_CH-1:0] channel_req,
  output logic [`NUM_CH-1:0] channel_grant,
  output logic [`NUM_CH-1:0] channel_enabled,
  // Injection resync FIFO
  input wire logic [5:0] inj_fifo_level,
  output logic bus_backpressure,
  // Interrupt
  output logic [`NUM_CH-1:0] interrupting_channels,
  output logic irq
);
  top_state_t s_r, s_nxt;
  logic [`NUM_CH-1:0] lnk_flags, frame_flags, tag_flags, err_flags;
  logic [`NUM_CH-1:0] lnk_clr, frame_clr, tag_clr, err_clr;
  logic [`NUM_CH-1:0] lnk_set, auto_stop, ident;
  logic wr_en, rd_setup, hit;
  logic [31:0] rd_val;
  logic [`NUM_CH-1:0] w1c;
  arb_if arb_bus ();

  // Zero wait state slave; writes land at the access edge
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign pslverr = psel && penable && !hit;
  assign w1c = pwdata[`NUM_CH-1:0];

  // Address decode and read mux
  always_comb begin
    hit = 1'b1;
    rd_val = 32'h0000_0000;
    case (paddr)
      `OFS_LNK_FLAGS: rd_val[`NUM_CH-1:0] = lnk_flags;
      `OFS_LNK_ENA: rd_val[`NUM_CH-1:0] = s_r.lnk_ena;
      `OFS_FRAME_FLAGS: rd_val[`NUM_CH-1:0] = frame_flags;
      `OFS_FRAME_ENA: rd_val[`NUM_CH-1:0] = s_r.frame_ena;
      `OFS_TAG_FLAGS: rd_val[`NUM_CH-1:0] = tag_flags;
      `OFS_TAG_ENA: rd_val[`NUM_CH-1:0] = s_r.tag_ena;
      `OFS_ERR_FLAGS: rd_val[`NUM_CH-1:0] = err_flags;
      `OFS_IRQ_ENA: rd_val[`NUM_CH-1:0] = s_r.irq_ena;
      `OFS_IDENT: rd_val[`NUM_CH-1:0] = ident;
      `OFS_CH_ENABLE: rd_val[`NUM_CH-1:0] = s_r.ch_enable;
      `OFS_GCFG: begin
        rd_val[`GCFG_WM_MSB:`GCFG_WM_LSB] = s_r.wm;
        rd_val[`GCFG_RSVD_MSB:`GCFG_RSVD_LSB] = s_r.gcfg_rsvd;
      end
      default: begin
        hit = 1'b0;
        for (int i = 0; i < `NUM_CH; i++) begin
          if (paddr == `OFS_CH_CFG0 + 12'(4 * i)) begin
            hit = 1'b1;
            rd_val[4:0] = s_r.ch_cfg[i];
          end
          if (paddr == `OFS_PREV_PTR0 + 12'(4 * i)) begin
            hit = 1'b1;
            rd_val = s_r.prev_ptr[i];
          end
        end
      end
    endcase
  end

  // Clear strobes for the W1C banks
  always_comb begin
    lnk_clr = '0;
    frame_clr = '0;
    tag_clr = '0;
    err_clr = '0;
    if (wr_en) begin
      if (paddr == `OFS_LNK_FLAGS) lnk_clr = w1c;
      if (paddr == `OFS_FRAME_FLAGS) frame_clr = w1c;
      if (paddr == `OFS_TAG_FLAGS) tag_clr = w1c;
      if (paddr == `OFS_ERR_FLAGS) err_clr = w1c;
    end
  end

  // Auto stop only after the completion word is already written back
  always_comb begin
    for (int i = 0; i < `NUM_CH; i++) begin
      auto_stop[i] = s_r.ch_enable[i] && desc_done[i] &&
        (s_r.ch_cfg[i].stop_done ||
         (s_r.ch_cfg[i].stop_eof && desc_done_eof[i]));
    end
    lnk_set = link_pointer_event | auto_stop;
  end

  // Event flag banks, one per event kind
  sticky_flags u_lnk (
    .core_clk(core_clk),
    .reset(reset),
    .set(lnk_set),
    .clr(lnk_clr),
    .flags(lnk_flags)
  );
  sticky_flags u_frame (
    .core_clk(core_clk),
    .reset(reset),
    .set(frame_event),
    .clr(frame_clr),
    .flags(frame_flags)
  );
  sticky_flags u_tag (
    .core_clk(core_clk),
    .reset(reset),
    .set(tagged_descriptor_event),
    .clr(tag_clr),
    .flags(tag_flags)
  );
  sticky_flags u_err (
    .core_clk(core_clk),
    .reset(reset),
    .set(fault_event),
    .clr(err_clr),
    .flags(err_flags)
  );

  // Interrupt gating; faults bypass the per-event enables
  assign ident = s_r.irq_ena & (err_flags |
    (lnk_flags & s_r.lnk_ena) |
    (frame_flags & s_r.frame_ena) |
    (tag_flags & s_r.tag_ena));
  assign interrupting_channels = ident;
  assign irq = |ident;

  // Arbitration over enabled, requesting channels
  always_comb begin
    arb_bus.req = channel_req & s_r.ch_enable;
    for (int i = 0; i < `NUM_CH; i++) begin
      arb_bus.prio[i] = s_r.ch_cfg[i].prio;
    end
  end
  prio_arbiter u_arb (
    .bus(arb_bus)
  );
  assign channel_grant = arb_bus.grant;

  // Backpressure compares against watermark plus one
  assign bus_backpressure =
    ({1'h0, inj_fifo_level} >= ({2'h0, s_r.wm} + 7'h01));

  // Register writes, descriptor load and read capture
  always_comb begin
    s_nxt = s_r;
    if (wr_en) begin
      case (paddr)
        `OFS_LNK_ENA: s_nxt.lnk_ena = pwdata[`NUM_CH-1:0];
        `OFS_FRAME_ENA: s_nxt.frame_ena = pwdata[`NUM_CH-1:0];
        `OFS_TAG_ENA: s_nxt.tag_ena = pwdata[`NUM_CH-1:0];
        `OFS_IRQ_ENA: s_nxt.irq_ena = pwdata[`NUM_CH-1:0];
        `OFS_GCFG: begin
          s_nxt.wm = pwdata[`GCFG_WM_MSB:`GCFG_WM_LSB];
          s_nxt.gcfg_rsvd = pwdata[`GCFG_RSVD_MSB:`GCFG_RSVD_LSB];
        end
        default: begin
          for (int i = 0; i < `NUM_CH; i++) begin
            if (paddr == `OFS_CH_CFG0 + 12'(4 * i)) begin
              s_nxt.ch_cfg[i] = pwdata[4:0];
            end
          end
        end
      endcase
    end
    // Software enable write overrides a stop in the same cycle
    if (wr_en && paddr == `OFS_CH_ENABLE) begin
      s_nxt.ch_enable = pwdata[`NUM_CH-1:0];
    end else begin
      s_nxt.ch_enable = s_r.ch_enable & ~auto_stop;
    end
    if (desc_load) begin
      s_nxt.load_ch = desc_load_ch;
      if (s_r.ch_cfg[desc_load_ch].sib) begin
        s_nxt.stat_addr = buffer_pointer;
        s_nxt.data_addr = buffer_pointer + `STAT_IN_BUF_BYTES;
        s_nxt.prev_ptr[desc_load_ch] = buffer_pointer;
      end else begin
        s_nxt.stat_addr = desc_addr + `STAT_WORD_OFS;
        s_nxt.data_addr = buffer_pointer;
        s_nxt.prev_ptr[desc_load_ch] = desc_addr;
      end
    end
    // Read data sampled in setup so it stands through access
    if (rd_setup) begin
      s_nxt.rdata = rd_val;
    end
  end

  // Single state register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_r <= '0;
      s_r.irq_ena <= `RST_IRQ_ENA;
      s_r.wm <= `RST_WM;
      s_r.gcfg_rsvd <= `RST_RSVD;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.rdata;
  assign data_start_addr = s_r.data_addr;
  assign status_word_addr = s_r.stat_addr;
  assign load_ch = s_r.load_ch;
  assign channel_enabled = s_r.ch_enable;
endmodule // frame_dma_engine

// ==== src/frame_dma_defs.svh ====
// Overview of operation
// - Sticky per-channel frame event flag, four bits, held until software clears.
// - Frame flag reaches interrupt only when its enable is set; enables reset zero.
// - Sticky per-channel tagged-descriptor event flag, four bits, held until cleared.
// - Tagged flag reaches interrupt only when its enable is set; enables reset zero.
// - Channel interrupt enable gates link, frame, tagged events; resets to all ones.
// - Fault flag reaches interrupt whenever channel interrupt enable is set.
// - Read-only vector shows interrupting channels; zero after reset.
// - Status-in-buffer: completion word goes to buffer pointer, not descriptor.
// - Status-in-buffer: buffer pointer advanced by four on load, data placed after.
// - Status-in-buffer: previous link readback holds buffer pointer; not a link.
// - Strict priority across all channels via two-bit field, reset zero.
// - Extraction channels with data take highest priority among such channels.
// - Equal priority: higher channel number wins, so injection beats extraction.
// - Stop-on-done disables channel after completing any descriptor.
// - Stop-on-end-of-frame disables channel after completing descriptor with EOF.
// - Auto stop: write back completion, then disable with link event same cycle.
// - Backpressure when FIFO holds watermark plus one or more; watermark resets 14.
// - Sticky link-pointer event flags, four bits, gated by enable resetting zero.
// - Sticky fault flags, four bits, set when a run-time check fails.
// - Two injection and two extraction channels, numbered zero to three.
`ifndef FRAME_DMA_DEFS_SVH
`define FRAME_DMA_DEFS_SVH

// Channel count and roles
`define NUM_CH 4
`define NUM_XTR 2

// Register byte offsets
`define OFS_LNK_FLAGS 12'h000
`define OFS_LNK_ENA 12'h004
`define OFS_FRAME_FLAGS 12'h008
`define OFS_FRAME_ENA 12'h00C
`define OFS_TAG_FLAGS 12'h010
`define OFS_TAG_ENA 12'h014
`define OFS_ERR_FLAGS 12'h018
`define OFS_IRQ_ENA 12'h01C
`define OFS_IDENT 12'h020
`define OFS_GCFG 12'h024
`define OFS_CH_ENABLE 12'h028
`define OFS_CH_CFG0 12'h030
`define OFS_PREV_PTR0 12'h040

// Field positions of the global config
`define GCFG_WM_LSB 7
`define GCFG_WM_MSB 11
`define GCFG_RSVD_LSB 3
`define GCFG_RSVD_MSB 6

// Reset values
`define RST_IRQ_ENA 4'hF
`define RST_WM 5'h0E
`define RST_RSVD 4'h9

// Layout of a descriptor and buffer
`define STAT_WORD_OFS 32'h0000_000C
`define STAT_IN_BUF_BYTES 32'h0000_0004

`endif

// ==== src/frame_dma_pkg.sv ====
`include "frame_dma_defs.svh"
package frame_dma_pkg;

  // Sticky flag bank
  typedef struct packed {
    logic [`NUM_CH-1:0] flags;
  } sticky_state_t;

  // Per-channel config, bit 4 down to bit 0
  typedef struct packed {
    logic sib;
    logic [1:0] prio;
    logic stop_done;
    logic stop_eof;
  } ch_cfg_t;

  // Whole state of the top module
  typedef struct packed {
    logic [`NUM_CH-1:0] lnk_ena;
    logic [`NUM_CH-1:0] frame_ena;
    logic [`NUM_CH-1:0] tag_ena;
    logic [`NUM_CH-1:0] irq_ena;
    logic [`NUM_CH-1:0] ch_enable;
    ch_cfg_t [`NUM_CH-1:0] ch_cfg;
    logic [4:0] wm;
    logic [3:0] gcfg_rsvd;
    logic [`NUM_CH-1:0][31:0] prev_ptr;
    logic [31:0] data_addr;
    logic [31:0] stat_addr;
    logic [1:0] load_ch;
    logic [31:0] rdata;
  } top_state_t;

endpackage

// ==== src/arb_if.sv ====
`timescale 1ns/10ps
`include "frame_dma_defs.svh"
interface arb_if;
  logic [`NUM_CH-1:0] req;
  logic [`NUM_CH-1:0][1:0] prio;
  logic [`NUM_CH-1:0] grant;
  modport arb (input req, input prio, output grant);
  modport user (output req, output prio, input grant);
endinterface

// ==== src/sticky_flags.sv ====
`timescale 1ns/10ps
`include "frame_dma_defs.svh"
module sticky_flags import frame_dma_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Event and clear strobes
  input wire logic [`NUM_CH-1:0] set,
  input wire logic [`NUM_CH-1:0] clr,
  // Current flags
  output logic [`NUM_CH-1:0] flags
);
  sticky_state_t s_r, s_nxt;

  // Set has the last word so an event during a clear survives
  always_comb begin
    s_nxt = s_r;
    s_nxt.flags = (s_r.flags & ~clr) | set;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign flags = s_r.flags;
endmodule // sticky_flags

// ==== src/prio_arbiter.sv ====
`timescale 1ns/10ps
`include "frame_dma_defs.svh"
module prio_arbiter import frame_dma_pkg::*; (
  // Requests, priorities and grant
  arb_if.arb bus
);
  logic [1:0] xtr_max;
  logic [`NUM_CH-1:0][1:0] eff;
  logic [1:0] best;
  logic found;

  // Pure combinational pick; no state kept
  always_comb begin
    xtr_max = 2'h0;
    for (int i = 0; i < `NUM_XTR; i++) begin
      if (bus.req[i] && bus.prio[i] > xtr_max) begin
        xtr_max = bus.prio[i];
      end
    end
    for (int i = 0; i < `NUM_CH; i++) begin
      eff[i] = (i < `NUM_XTR) ? xtr_max : bus.prio[i];
    end
    best = 2'h0;
    found = 1'b0;
    bus.grant = '0;
    // Ascending scan with >= lets higher numbers win ties
    for (int i = 0; i < `NUM_CH; i++) begin
      if (bus.req[i] && (!found || eff[i] >= best)) begin
        best = eff[i];
        found = 1'b1;
        bus.grant = '0;
        bus.grant[i] = 1'b1;
      end
    end
  end
endmodule // prio_arbiter

// ==== tb/far_side_model.sv ====
`timescale 1ns/10ps
module far_side_model (
  // Clock and run control
  input wire logic core_clk,
  input wire logic go,
  // Queue and bus side activity
  output logic [3:0] req = 4'h0,
  output logic [5:0] lvl = 6'h00,
  output logic [3:0] fev = 4'h0,
  output logic [3:0] tev = 4'h0,
  output logic [3:0] lev = 4'h0,
  output logic [3:0] xev = 4'h0,
  output logic [3:0] done = 4'h0,
  output logic [3:0] eof = 4'h0
);
  // Sparse one-cycle pulses, so flags get time to be seen and cleared
  always @(posedge core_clk) begin
    if (go) begin
      req <= 4'($urandom);
      lvl <= 6'($urandom % 40);
      fev <= 4'($urandom & $urandom & $urandom);
      tev <= 4'($urandom & $urandom & $urandom);
      lev <= 4'($urandom & $urandom & $urandom);
      xev <= 4'($urandom & $urandom & $urandom & $urandom);
      done <= 4'($urandom & $urandom);
      eof <= 4'($urandom);
    end
  end
endmodule // far_side_model

// ==== tb/frame_dma_asserts.sv ====
`timescale 1ns/10ps
`include "frame_dma_defs.svh"
module frame_dma_asserts (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Register bus
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  // Events and descriptors
  input wire logic [`NUM_CH-1:0] fault_event,
  input wire logic [`NUM_CH-1:0] desc_done,
  input wire logic desc_load,
  input wire logic [31:0] desc_addr,
  input wire logic [31:0] buffer_pointer,
  input wire logic [31:0] data_start_addr,
  input wire logic [31:0] status_word_addr,
  // Arbitration, backpressure, interrupt
  input wire logic [`NUM_CH-1:0] channel_req,
  input wire logic [`NUM_CH-1:0] channel_grant,
  input wire logic [`NUM_CH-1:0] channel_enabled,
  input wire logic [5:0] inj_fifo_level,
  input wire logic bus_backpressure,
  input wire logic [`NUM_CH-1:0] interrupting_channels,
  input wire logic irq
);
  logic [3:0] ie_r;
  logic [4:0] wm_r;
  logic wr;
  logic en_wr;
  logic [3:0] fault_ie;
  assign wr = psel & penable & pwrite;
  // Helpers so that sampled-value functions see plain signals
  assign en_wr = wr && paddr == `OFS_CH_ENABLE;
  assign fault_ie = fault_event & ie_r;
  // Shadows of settings, seen only through the bus
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ie_r <= `RST_IRQ_ENA;
      wm_r <= `RST_WM;
    end else if (wr && paddr == `OFS_IRQ_ENA) begin
      ie_r <= pwdata[3:0];
    end else if (wr && paddr == `OFS_GCFG) begin
      wm_r <= pwdata[11:7];
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // Two legal placements of a loaded descriptor
  sequence s_in_buf;
    status_word_addr == $past(buffer_pointer) &&
      data_start_addr == $past(buffer_pointer) + `STAT_IN_BUF_BYTES;
  endsequence
  sequence s_in_desc;
    status_word_addr == $past(desc_addr) + `STAT_WORD_OFS &&
      data_start_addr == $past(buffer_pointer);
  endsequence
  a_irq_is_or: assert property (irq == |interrupting_channels)
    else $error("irq differs from OR of ident");
  a_ident_masked: assert property ((interrupting_channels & ~ie_r) == 4'h0)
    else $error("ident set on masked channel");
  a_ident_rst: assert property ($past(reset) |-> interrupting_channels == 4'h0)
    else $error("ident not zero after reset");
  a_fault_ident: assert property (fault_ie != 4'h0 && !wr |=>
    (interrupting_channels & $past(fault_ie)) == $past(fault_ie))
    else $error("fault not shown in ident");
  a_grant_onehot: assert property ($onehot0(channel_grant))
    else $error("grant not one-hot");
  a_grant_legal: assert property (
    (channel_grant & ~(channel_req & channel_enabled)) == 4'h0)
    else $error("grant to idle channel");
  a_grant_any: assert property (
    |(channel_req & channel_enabled) |-> |channel_grant)
    else $error("no grant with requests");
  a_bp_level: assert property (bus_backpressure ==
    (inj_fifo_level >= {1'h0, wm_r} + 6'h01))
    else $error("backpressure level wrong");
  a_stop_cause: assert property (
    !$past(reset) && !$past(en_wr) |->
      ($past(channel_enabled) & ~channel_enabled & ~$past(desc_done)) == 4'h0)
    else $error("channel stopped without done");
  a_load_addrs: assert property (desc_load |=> s_in_buf or s_in_desc)
    else $error("descriptor addresses wrong");
endmodule // frame_dma_asserts

bind frame_dma_engine frame_dma_asserts i_frame_dma_asserts (
  .core_clk(core_clk), .reset(reset), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .fault_event(fault_event), .desc_done(desc_done), .desc_load(desc_load),
  .desc_addr(desc_addr), .buffer_pointer(buffer_pointer),
  .data_start_addr(data_start_addr), .status_word_addr(status_word_addr),
  .channel_req(channel_req), .channel_grant(channel_grant),
  .channel_enabled(channel_enabled), .inj_fifo_level(inj_fifo_level),
  .bus_backpressure(bus_backpressure),
  .interrupting_channels(interrupting_channels), .irq(irq));

// ==== tb/frame_dma_irq_and_channel_cfg_tb.sv ====
`timescale 1ns/10ps
`include "frame_dma_defs.svh"
module frame_dma_irq_and_channel_cfg_tb;
  logic core_clk = 0, reset = 1, go = 0;
  logic psel = 0, penable = 0, pwrite = 0, desc_load = 0, pready, pslverr;
  logic [11:0] paddr = 0;
  logic [1:0] desc_load_ch = 0, lch;
  logic [31:0] pwdata = 0, desc_addr = 0, buffer_pointer = 0;
  logic [31:0] prdata, dsa, swa, exp_rd, m_dsa, m_swa, m_prev[4];
  logic [3:0] fev, tev, lev, xev, done, eof, req, grant, en, ident;
  logic [3:0] m_lnk, m_frame, m_tag, m_err, m_le, m_fe, m_se, m_ie, m_en;
  logic [4:0] m_wm, m_cfg[4];
  logic [3:0] m_rs;
  logic [1:0] m_lch;
  logic [5:0] lvl;
  logic bp, irq;
  int error_cnt = 0, checks_done = 0;

  always #20 core_clk = ~core_clk;

  frame_dma_engine i_frame_dma_engine (.core_clk(core_clk), .reset(reset),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_event(fev), .tagged_descriptor_event(tev),
    .link_pointer_event(lev), .fault_event(xev), .desc_done(done),
    .desc_done_eof(eof), .desc_load(desc_load), .desc_load_ch(desc_load_ch),
    .desc_addr(desc_addr), .buffer_pointer(buffer_pointer),
    .data_start_addr(dsa), .status_word_addr(swa), .load_ch(lch),
    .channel_req(req), .channel_grant(grant), .channel_enabled(en),
    .inj_fifo_level(lvl), .bus_backpressure(bp),
    .interrupting_channels(ident), .irq(irq));
  far_side_model i_far_side_model (.core_clk(core_clk), .go(go), .req(req),
    .lvl(lvl), .fev(fev), .tev(tev), .lev(lev), .xev(xev), .done(done),
    .eof(eof));

  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask

  function automatic logic [31:0] rd(logic [11:0] a);
    case (a)
      12'h000: return {28'h0, m_lnk};
      12'h004: return {28'h0, m_le};
      12'h008: return {28'h0, m_frame};
      12'h00C: return {28'h0, m_fe};
      12'h010: return {28'h0, m_tag};
      12'h014: return {28'h0, m_se};
      12'h018: return {28'h0, m_err};
      12'h01C: return {28'h0, m_ie};
      12'h020: return {28'h0, m_ie & (m_err | m_lnk & m_le | m_frame & m_fe
        | m_tag & m_se)};
      12'h024: return {20'h0, m_wm, m_rs, 3'h0};
      12'h028: return {28'h0, m_en};
      12'h030, 12'h034, 12'h038, 12'h03C: return {27'h0, m_cfg[a[3:2]]};
      12'h040, 12'h044, 12'h048, 12'h04C: return m_prev[a[3:2]];
      default: return 32'h0;
    endcase
  endfunction

  // Strict priority, extraction lifted to its best waiting peer
  function automatic logic [3:0] gr(logic [3:0] r);
    int x, b, w, e;
    x = -1;
    b = -1;
    w = -1;
    for (int i = 0; i < 2; i++)
      if (r[i] && int'(m_cfg[i][3:2]) > x) x = m_cfg[i][3:2];
    for (int i = 0; i < 4; i++) begin
      e = i < 2 ? x : int'(m_cfg[i][3:2]);
      if (r[i] && e >= b) begin
        b = e;
        w = i;
      end
    end
    return w < 0 ? 4'h0 : 4'h1 << w;
  endfunction

  // Reference model, updated on the same edges as the design
  always @(posedge core_clk) begin
    logic [3:0] st;
    logic s;
    if (reset) begin
      {m_lnk, m_frame, m_tag, m_err, m_le, m_fe, m_se, m_en} = 32'h0;
      m_ie = 4'hF;
      m_wm = 5'h0E;
      m_rs = 4'h9;
      {m_dsa, m_swa, m_lch} = 66'h0;
      foreach (m_cfg[i]) {m_cfg[i], m_prev[i]} = 37'h0;
    end else begin
      if (psel && !penable && !pwrite) exp_rd = rd(paddr);
      for (int i = 0; i < 4; i++)
        st[i] = done[i] & m_en[i] & (m_cfg[i][1] | m_cfg[i][0] & eof[i]);
      if (desc_load) begin
        s = m_cfg[desc_load_ch][4];
        m_lch = desc_load_ch;
        m_swa = s ? buffer_pointer : desc_addr + 32'h0000_000C;
        m_dsa = s ? buffer_pointer + 32'h0000_0004 : buffer_pointer;
        m_prev[desc_load_ch] = s ? buffer_pointer : desc_addr;
      end
      m_en &= ~st;
      m_lnk |= lev | st;
      m_frame |= fev;
      m_tag |= tev;
      m_err |= xev;
      if (psel && penable && pwrite) case (paddr)
        12'h000: m_lnk &= ~pwdata[3:0] | lev | st;
        12'h004: m_le = pwdata[3:0];
        12'h008: m_frame &= ~pwdata[3:0] | fev;
        12'h00C: m_fe = pwdata[3:0];
        12'h010: m_tag &= ~pwdata[3:0] | tev;
        12'h014: m_se = pwdata[3:0];
        12'h018: m_err &= ~pwdata[3:0] | xev;
        12'h01C: m_ie = pwdata[3:0];
        12'h024: {m_wm, m_rs} = pwdata[11:3];
        12'h028: m_en = pwdata[3:0];
        12'h030, 12'h034, 12'h038, 12'h03C: m_cfg[paddr[3:2]] = pwdata[4:0];
        default: ;
      endcase
    end
  end

  // Settled outputs compared mid-cycle
  always @(negedge core_clk) if (!reset) begin
    chk("ident", rd(12'h020), {28'h0, ident});
    chk("irq", {31'h0, |rd(12'h020)}, {31'h0, irq});
    chk("grant", {28'h0, gr(req & m_en)}, {28'h0, grant});
    chk("bp", {31'h0, lvl >= {1'h0, m_wm} + 6'h01}, {31'h0, bp});
    chk("enabled", {28'h0, m_en}, {28'h0, en});
    chk("status", m_swa, swa);
    chk("data", m_dsa, dsa);
    chk("loadch", {30'h0, m_lch}, {30'h0, lch});
  end

  // Descriptor loads from the transfer side
  always @(posedge core_clk) if (go) begin
    desc_load <= 1'($urandom % 3 == 0);
    desc_load_ch <= 2'($urandom);
    desc_addr <= $urandom;
    buffer_pointer <= $urandom;
  end

  task automatic apb(logic [11:0] a, logic w, logic [31:0] d);
    psel <= 1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    do @(posedge core_clk); while (pready !== 1'b1);
    if (!w) chk("prdata", exp_rd, prdata);
    chk("pslverr", {31'h0, a > 12'h04C || a == 12'h02C}, {31'h0, pslverr});
    psel <= 0;
    penable <= 0;
    @(posedge core_clk);
  endtask

  task automatic print_verdict;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #400000;
    error_cnt++;
    print_verdict;
  end

  initial begin
    int a;
    logic [31:0] d;
    void'($urandom(32'h0598_25b2));
    repeat (2) @(posedge core_clk);
    reset <= 0;
    // Reset values of every place, plus two unmapped words
    for (a = 0; a < 84; a += 4) apb(12'(a), 0, 32'h0);
    go <= 1;
    repeat (400) begin
      a = ($urandom % 21) * 4;
      d = $urandom;
      if (a == 36) d[6:3] = 4'h9;
      if (a == 40) d[3:0] = 4'hF;
      apb(12'(a), 1'($urandom), d);
    end
    print_verdict;
  end
endmodule // frame_dma_irq_and_channel_cfg_tb
